// >>> common/clsf_pkg.sv
// Constants shared by the cascaded LED serial front end.
// Assumes the link is sampled by a single 100 MHz system clock.
package clsf_pkg;

  // ****************************************
  // Header layout
  // ****************************************
  localparam int HEAD_BITS = 24;
  localparam int SYNC_BITS = 8;
  localparam int CMD_BITS = 6;
  localparam int TALLY_BITS = 10;
  localparam logic [7:0] SYNC_PATTERN = 8'he8;
  localparam logic [4:0] HEAD_LAST_BIT = 5'h0f;
  localparam logic [4:0] FRAME_RISE_LIMIT = 5'h02;
  localparam logic [23:0] FRAME_OUT_PATTERN = 24'h00ffff;

  // ****************************************
  // Commands and data lengths
  // ****************************************
  typedef enum logic [1:0] {
    CMD_PWM = 2'h0,
    CMD_CALIBRATION = 2'h1,
    CMD_GLOBAL = 2'h2,
    CMD_CONFIG = 2'h3
  } clsf_cmd_type;
  localparam int DRIVER_OUTPUTS = 24;
  localparam int SHORT_DATA_BITS = 24;
  localparam int PWM_WIDTH_DEFAULT = 12;

  // ****************************************
  // Configuration byte
  // ****************************************
  localparam int CFG_QUARTER_POS = 4;
  localparam int CFG_OUTEN_POS = 3;
  localparam int CFG_CNT_RESET_POS = 2;
  localparam int CFG_WATCHDOG_POS = 1;
  localparam int CFG_MUX_POS = 0;
  localparam logic [7:0] CFG_RESET = 8'h00;

  // ****************************************
  // Own data buffer
  // ****************************************
  localparam int OWN_FIFO_WIDTH = 8;
  localparam int OWN_FIFO_DEPTH = 16;

endpackage : clsf_pkg

// >>> rtl/clsf_sync.sv
// Two-flop synchroniser for a group of level inputs.
// Assumes inputs are asynchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
module clsf_sync #(
  parameter int WIDTH = 3
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } clsf_sync_type;

  clsf_sync_type s_reg;
  clsf_sync_type s_next;

  always_comb begin
    s_next = s_reg;
    s_next.first = async_i;
    s_next.second = s_reg.first;
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign sync_o = s_reg.second;

endmodule : clsf_sync
`default_nettype wire

// >>> rtl/clsf_fifo.sv
// Synchronous FIFO with valid/ready on both sides and registered flags.
// Assumes one clock; DEPTH a power of two.
`timescale 1ns/1ps
`default_nettype none
module clsf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("clsf_fifo: DEPTH must be a power of two of at least 2");
  end

  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic not_empty;
    logic not_full;
  } clsf_fifo_type;

  clsf_fifo_type s_reg;
  clsf_fifo_type s_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  always_comb begin
    push = in_valid_i && s_reg.not_full;
    pop = out_ready_i && s_reg.not_empty;
    s_next = s_reg;
    if (push) begin
      s_next.wr_ptr = s_reg.wr_ptr + 1'b1;
    end
    if (pop) begin
      s_next.rd_ptr = s_reg.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      s_next.count = s_reg.count + 1'b1;
    end else if (pop && !push) begin
      s_next.count = s_reg.count - 1'b1;
    end
    s_next.not_empty = s_next.count != '0;
    s_next.not_full = s_next.count != (AW+1)'(DEPTH);
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      s_reg <= '0;
      s_reg.not_full <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[s_reg.wr_ptr] <= in_data_i;
    end
  end

  assign in_ready_o = s_reg.not_full;
  assign out_valid_o = s_reg.not_empty;
  assign out_data_o = mem[s_reg.rd_ptr];

endmodule : clsf_fifo
`default_nettype wire

// >>> rtl/clsf_frontend.sv
// Receive-and-forward front end of a cascadable LED driver serial link.
// Assumes the link clock is far slower than clk_i (at least 3 clk_i periods per half period).
//
// Overview of operation
// - Sample data and frame on link clock rises; update outputs on those rises.
// - A transfer is header, then data, then optional tail, in order.
// - Header and tail go downstream; own data is removed from the stream.
// - While frame is low, search incoming data for the alignment pattern.
// - Header is 24 bits: 8-bit pattern, 6-bit command, 10-bit fault tally.
// - After pattern 0xE8, the frame rise aligns internal frame timing.
// - Command field repeats the two command bits three times.
// - A faulty device adds exactly one to the passing fault tally.
// - D4 selects reduced global intensity; reset 0; ignored in 12-bit variant.
// - D3 enables outputs; clearing it disables drivers, settings kept.
// - D2 clears subframe and PWM counters, then returns to 0 itself.
// - D1 enables the watchdog; resets to 0.
// - D0 enables multiplex mode; resets to 0.
// - Chain position alone decides which data a device takes.
// - Commands: 00 PWM, 01 calibration, 10 global intensity, 11 configuration.
// - Configuration byte is sent three times and applies at once.
// - Command low bit 0 counts overtemperature, 1 counts open-LED faults.
`timescale 1ns/1ps
`default_nettype none
module clsf_frontend #(
  parameter int PWM_WIDTH = clsf_pkg::PWM_WIDTH_DEFAULT,
  parameter int FIFO_DEPTH = clsf_pkg::OWN_FIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic upstream_clock_in_i,
  input wire logic upstream_data_in_i,
  input wire logic upstream_frame_in_i,
  input wire logic fault_overtemp_i,
  input wire logic fault_open_led_i,
  output logic downstream_clock_out_o,
  output logic downstream_data_out_o,
  output logic downstream_frame_out_o,
  output logic [1:0] command_o,
  output logic command_valid_o,
  output logic frame_error_o,
  output logic quarter_global_enable_o,
  output logic outputs_enable_o,
  output logic counter_reset_o,
  output logic watchdog_enable_o,
  output logic multiplex_enable_o,
  output logic [7:0] own_data_o,
  output logic own_valid_o,
  input wire logic own_ready_i,
  output logic own_overflow_o
);

  // ****************************************
  // Parameter checks and derived sizes
  // ****************************************
  if (PWM_WIDTH != 12 && PWM_WIDTH != 14) begin : g_bad_width
    $error("clsf_frontend: PWM_WIDTH must be 12 or 14");
  end

  localparam int NONMUX_BITS = clsf_pkg::DRIVER_OUTPUTS * PWM_WIDTH;
  localparam int MUX_BITS = 2 * NONMUX_BITS;
  localparam int LEN_W = $clog2(MUX_BITS + 1);

  typedef enum logic [3:0] {
    PH_HUNT = 4'b0001,
    PH_HEADER = 4'b0010,
    PH_OWN = 4'b0100,
    PH_FORWARD = 4'b1000
  } clsf_phase_type;

  typedef struct packed {
    clsf_phase_type phase;
    logic clk_prev;
    logic frame_prev;
    logic [23:0] shift;
    logic [4:0] head_cnt;
    logic rise_seen;
    logic [1:0] cmd;
    logic [23:0] head_out;
    logic [LEN_W-1:0] own_len;
    logic [LEN_W-1:0] own_cnt;
    logic [7:0] byte_sh;
    logic [2:0] bit_cnt;
    logic [23:0] cfg_sh;
    logic [23:0] pipe;
    logic [23:0] fpipe;
    logic dclk;
    logic dout;
    logic dframe;
    logic cmd_valid;
    logic frame_error;
    logic quarter;
    logic outen;
    logic cnt_reset;
    logic watchdog;
    logic multiplex_enable;
    logic push_valid;
    logic [7:0] push_data;
    logic overflow;
  } clsf_state_type;

  clsf_state_type s_reg;
  clsf_state_type s_next;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [7:0] vote3(input logic [7:0] a, input logic [7:0] b,
                                       input logic [7:0] c);
    vote3 = (a & b) | (a & c) | (b & c);
  endfunction : vote3

  function automatic logic [LEN_W-1:0] own_length(input logic [1:0] cmd, input logic multiplex_enable);
    logic [LEN_W-1:0] len;
    len = LEN_W'(clsf_pkg::SHORT_DATA_BITS);
    if (cmd == clsf_pkg::CMD_PWM) begin
      len = multiplex_enable ? LEN_W'(MUX_BITS) : LEN_W'(NONMUX_BITS);
    end
    own_length = len;
  endfunction : own_length

  // ****************************************
  // Input synchronisation
  // ****************************************
  logic [2:0] link_sync;
  logic fifo_in_ready;

  clsf_sync #(
    .WIDTH(3)
  ) u_sync (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .async_i({upstream_clock_in_i, upstream_data_in_i, upstream_frame_in_i}),
    .sync_o(link_sync)
  );

  logic lclk;
  logic din;
  logic fin;
  logic tick;
  logic rise;
  logic [23:0] sh_n;
  logic [7:0] voted;
  logic [7:0] cmd_vote;
  logic [1:0] cmd_n;
  logic fault;
  logic [9:0] tally_n;
  logic [23:0] cfg_n;

  // ****************************************
  // Link state machine
  // ****************************************
  always_comb begin
    lclk = link_sync[2];
    din = link_sync[1];
    fin = link_sync[0];
    tick = lclk && !s_reg.clk_prev;
    rise = fin && !s_reg.frame_prev;
    sh_n = {s_reg.shift[22:0], din};
    cmd_vote = vote3({6'h00, sh_n[15:14]}, {6'h00, sh_n[13:12]},
                     {6'h00, sh_n[11:10]});
    cmd_n = cmd_vote[1:0];
    fault = cmd_n[0] ? fault_open_led_i : fault_overtemp_i;
    tally_n = sh_n[9:0] + {9'h000, fault};
    cfg_n = {s_reg.cfg_sh[22:0], din};
    voted = vote3(cfg_n[23:16], cfg_n[15:8], cfg_n[7:0]);
    s_next = s_reg;
    s_next.clk_prev = lclk;
    s_next.dclk = s_reg.clk_prev;
    s_next.cmd_valid = 1'b0;
    s_next.frame_error = 1'b0;
    s_next.cnt_reset = 1'b0;
    s_next.push_valid = 1'b0;
    if (s_reg.push_valid && !fifo_in_ready) begin
      s_next.overflow = 1'b1;
    end
    if (tick) begin
      s_next.frame_prev = fin;
      s_next.shift = sh_n;
      // Forwarding pipe drains old tail; zeros fill it while a header is held back
      s_next.pipe = {s_reg.pipe[22:0], din};
      s_next.fpipe = {s_reg.fpipe[22:0], fin};
      s_next.dout = s_reg.pipe[23];
      s_next.dframe = s_reg.fpipe[23];
      case (s_reg.phase)
        PH_HUNT: begin
          if (!fin || rise) begin
            if (sh_n[7:0] == clsf_pkg::SYNC_PATTERN) begin
              s_next.phase = PH_HEADER;
              s_next.head_cnt = '0;
              s_next.rise_seen = rise;
            end
          end
        end
        PH_HEADER: begin
          s_next.pipe = {s_reg.pipe[22:0], 1'b0};
          s_next.fpipe = {s_reg.fpipe[22:0], 1'b0};
          s_next.head_cnt = s_reg.head_cnt + 5'h01;
          if (rise && s_reg.head_cnt < clsf_pkg::FRAME_RISE_LIMIT) begin
            s_next.rise_seen = 1'b1;
          end
          // A rise two or more bits late is refused as well
          if (!s_reg.rise_seen && s_reg.head_cnt == clsf_pkg::FRAME_RISE_LIMIT) begin
            s_next.phase = PH_HUNT;
            s_next.frame_error = 1'b1;
          end else if (s_reg.rise_seen && !fin) begin
            s_next.phase = PH_HUNT;
            s_next.frame_error = 1'b1;
          end else if (s_reg.head_cnt == clsf_pkg::HEAD_LAST_BIT) begin
            s_next.phase = PH_OWN;
            s_next.cmd = cmd_n;
            s_next.cmd_valid = 1'b1;
            s_next.head_out = {clsf_pkg::SYNC_PATTERN, sh_n[15:10], tally_n};
            s_next.own_len = own_length(cmd_n, s_reg.multiplex_enable);
            s_next.own_cnt = '0;
            s_next.bit_cnt = '0;
          end
        end
        PH_OWN: begin
          s_next.pipe = {s_reg.pipe[22:0], 1'b0};
          s_next.fpipe = {s_reg.fpipe[22:0], 1'b0};
          s_next.byte_sh = {s_reg.byte_sh[6:0], din};
          s_next.bit_cnt = s_reg.bit_cnt + 3'h1;
          s_next.cfg_sh = cfg_n;
          s_next.own_cnt = s_reg.own_cnt + 1'b1;
          if (s_reg.bit_cnt == 3'h7) begin
            s_next.push_valid = 1'b1;
            s_next.push_data = {s_reg.byte_sh[6:0], din};
          end
          if (!fin) begin
            s_next.phase = PH_HUNT;
            s_next.frame_error = 1'b1;
          end else if (s_reg.own_cnt == s_reg.own_len - 1'b1) begin
            s_next.phase = PH_FORWARD;
            // Header goes out now, ahead of the next device's data
            s_next.pipe = s_reg.head_out;
            s_next.fpipe = clsf_pkg::FRAME_OUT_PATTERN;
            s_next.dout = 1'b0;
            s_next.dframe = 1'b0;
            if (s_reg.cmd == clsf_pkg::CMD_CONFIG) begin
              s_next.quarter = (PWM_WIDTH == 12) ? 1'b0 : voted[clsf_pkg::CFG_QUARTER_POS];
              s_next.outen = voted[clsf_pkg::CFG_OUTEN_POS];
              s_next.cnt_reset = voted[clsf_pkg::CFG_CNT_RESET_POS];
              s_next.watchdog = voted[clsf_pkg::CFG_WATCHDOG_POS];
              s_next.multiplex_enable = voted[clsf_pkg::CFG_MUX_POS];
            end
          end
        end
        PH_FORWARD: begin
          if (!fin) begin
            s_next.phase = PH_HUNT;
          end
        end
        default: begin
          s_next.phase = PH_HUNT;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      s_reg <= '0;
      s_reg.phase <= PH_HUNT;
      s_reg.quarter <= clsf_pkg::CFG_RESET[clsf_pkg::CFG_QUARTER_POS];
      s_reg.outen <= clsf_pkg::CFG_RESET[clsf_pkg::CFG_OUTEN_POS];
      s_reg.watchdog <= clsf_pkg::CFG_RESET[clsf_pkg::CFG_WATCHDOG_POS];
      s_reg.multiplex_enable <= clsf_pkg::CFG_RESET[clsf_pkg::CFG_MUX_POS];
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************************************
  // Own data buffer
  // ****************************************
  logic [7:0] fifo_out_data;
  logic fifo_out_valid;

  clsf_fifo #(
    .WIDTH(clsf_pkg::OWN_FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .in_valid_i(s_reg.push_valid),
    .in_ready_o(fifo_in_ready),
    .in_data_i(s_reg.push_data),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(own_ready_i),
    .out_data_o(fifo_out_data)
  );

  // ****************************************
  // Outputs
  // ****************************************
  assign downstream_clock_out_o = s_reg.dclk;
  assign downstream_data_out_o = s_reg.dout;
  assign downstream_frame_out_o = s_reg.dframe;
  assign command_o = s_reg.cmd;
  assign command_valid_o = s_reg.cmd_valid;
  assign frame_error_o = s_reg.frame_error;
  assign quarter_global_enable_o = s_reg.quarter;
  assign outputs_enable_o = s_reg.outen;
  assign counter_reset_o = s_reg.cnt_reset;
  assign watchdog_enable_o = s_reg.watchdog;
  assign multiplex_enable_o = s_reg.multiplex_enable;
  assign own_data_o = fifo_out_data;
  assign own_valid_o = fifo_out_valid;
  assign own_overflow_o = s_reg.overflow;

endmodule : clsf_frontend
`default_nettype wire

// >>> tb/clsf_frontend_props.sv
// Port checker for the serial front end.
// Assumes a bind onto clsf_frontend; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module clsf_frontend_props #(
  parameter int PWM_WIDTH = 12
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic upstream_clock_in_i,
  input wire logic upstream_data_in_i,
  input wire logic upstream_frame_in_i,
  input wire logic fault_overtemp_i,
  input wire logic fault_open_led_i,
  input wire logic downstream_clock_out_o,
  input wire logic downstream_data_out_o,
  input wire logic downstream_frame_out_o,
  input wire logic [1:0] command_o,
  input wire logic command_valid_o,
  input wire logic frame_error_o,
  input wire logic quarter_global_enable_o,
  input wire logic outputs_enable_o,
  input wire logic counter_reset_o,
  input wire logic watchdog_enable_o,
  input wire logic multiplex_enable_o,
  input wire logic [7:0] own_data_o,
  input wire logic own_valid_o,
  input wire logic own_ready_i,
  input wire logic own_overflow_o
);
  // ****
  // Properties
  // ****
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);
  a_cfg_reset_clear: assert property ($rose(nrst_i) |-> !quarter_global_enable_o
    && !outputs_enable_o && !watchdog_enable_o && !multiplex_enable_o) else $error("cfg not 0");
  a_counter_reset_self_clear: assert property (counter_reset_o |=> !counter_reset_o)
    else $error("counter reset held");
  a_quarter_ignored: assert property ((PWM_WIDTH == 12) |-> !quarter_global_enable_o)
    else $error("quarter set in 12-bit");
  a_header_spacing: assert property (command_valid_o |=> !command_valid_o [*8])
    else $error("headers too close");
  a_data_on_tick: assert property ($changed(downstream_data_out_o) |=>
    $rose(downstream_clock_out_o)) else $error("data moved off tick");
  a_frame_on_tick: assert property ($changed(downstream_frame_out_o) |=>
    $rose(downstream_clock_out_o)) else $error("frame moved off tick");
  a_clock_forward: assert property ($rose(upstream_clock_in_i) |->
    ##[1:6] $rose(downstream_clock_out_o)) else $error("clock not forwarded");
  a_own_hold: assert property (own_valid_o && !own_ready_i |=>
    own_valid_o && $stable(own_data_o)) else $error("own byte lost");
  a_ovf_sticky: assert property (own_overflow_o |=> own_overflow_o)
    else $error("overflow cleared");
  a_cfg_by_load: assert property (($changed(outputs_enable_o) || $changed(watchdog_enable_o)
    || $changed(multiplex_enable_o)) |-> command_o == 2'h3) else $error("cfg w/o load");
  c_cfg_load: cover property (command_valid_o && command_o == 2'h3);
  c_counter_reset: cover property (counter_reset_o);
  c_ferr: cover property (frame_error_o);
  c_ovf: cover property (own_overflow_o);
endmodule : clsf_frontend_props
`default_nettype wire

// >>> tb/clsf_host_model.sv
// Host transmitter driving the link into the front end.
// Assumes the caller waits for send to return.
`timescale 1ns/1ps
`default_nettype none
module clsf_host_model (
  output logic lclk_o,
  output logic data_o,
  output logic frame_o
);
  // ****
  // Link
  // ****
  initial begin
    lclk_o = 1'b0;
    data_o = 1'b0;
    frame_o = 1'b0;
  end
  always #80 lclk_o = ~lclk_o;
  task automatic put(input logic d, input logic f);
    @(negedge lclk_o);
    data_o = d;
    frame_o = f;
  endtask : put
  task automatic send(input logic [1:0] c, input logic [23:0] p, input int n, input logic r);
    logic [23:0] head;
    head = {8'he8, {3{c}}, 10'h000};
    for (int i = 23; i >= 0; i--) put(head[i], r && i < 16);
    for (int i = 0; i < n; i++) put(r && p[23 - i % 24], r);
    for (int i = 0; i < 40; i++) put(i[0], r);
    for (int i = 0; i < 40; i++) put(1'b0, 1'b0);
  endtask : send
endmodule : clsf_host_model
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench for the serial front end.
// Assumes the host model drives the link pins.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin err_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic fault_overtemp_i = 1'b0;
  logic fault_open_led_i = 1'b0;
  logic own_ready_i = 1'b0;
  logic upstream_clock_in_i, upstream_data_in_i, upstream_frame_in_i;
  logic downstream_clock_out_o, downstream_data_out_o, downstream_frame_out_o;
  logic [1:0] command_o;
  logic command_valid_o, frame_error_o, quarter_global_enable_o, outputs_enable_o;
  logic counter_reset_o, watchdog_enable_o, multiplex_enable_o, own_valid_o, own_overflow_o;
  logic [7:0] own_data_o;
  logic [23:0] head_sr = 24'h0;
  logic [23:0] head_cap = 24'h0;
  logic dfr_prev = 1'b0;
  int err_count = 0, n_checks = 0, n_head = 0, n_counter_reset = 0, n_ferr = 0, hcnt = 0, cyc = 0, k;
  int n_cmd = 0;
  // ****
  // Design, host and monitors
  // ****
  clsf_frontend i_dut (.clk_i, .nrst_i, .upstream_clock_in_i, .upstream_data_in_i,
    .upstream_frame_in_i, .fault_overtemp_i, .fault_open_led_i, .downstream_clock_out_o,
    .downstream_data_out_o, .downstream_frame_out_o, .command_o, .command_valid_o,
    .frame_error_o, .quarter_global_enable_o, .outputs_enable_o, .counter_reset_o,
    .watchdog_enable_o, .multiplex_enable_o, .own_data_o, .own_valid_o, .own_ready_i,
    .own_overflow_o);
  clsf_host_model i_host (.lclk_o(upstream_clock_in_i), .data_o(upstream_data_in_i),
    .frame_o(upstream_frame_in_i));
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc++;
    n_counter_reset += int'(counter_reset_o === 1'b1);
    n_ferr += int'(frame_error_o === 1'b1);
    n_cmd += int'(command_valid_o === 1'b1);
    if (cyc == 80000) begin
      err_count++;
      give_verdict();
    end
  end
  // Capture each forwarded header, aligned on the frame rise
  always @(posedge downstream_clock_out_o) begin
    head_sr = {head_sr[22:0], downstream_data_out_o};
    if (downstream_frame_out_o && !dfr_prev) hcnt = 15;
    else if (hcnt > 0) begin
      hcnt--;
      if (hcnt == 0) begin
        head_cap = head_sr;
        n_head++;
      end
    end
    dfr_prev = downstream_frame_out_o;
  end
  // ****
  // Tasks
  // ****
  task automatic run(input logic [1:0] c, input logic [23:0] p, input int n, input logic r);
    i_host.send(c, p, n, r);
    @(negedge clk_i);
  endtask : run
  task automatic pop(input logic [7:0] e);
    `CHK(own_valid_o, 1'b1)
    `CHK(own_data_o, e)
    own_ready_i = 1'b1;
    @(negedge clk_i);
    own_ready_i = 1'b0;
    @(negedge clk_i);
  endtask : pop
  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  // ****
  // Sequence
  // ****
  initial begin
    repeat (3) @(negedge clk_i);
    nrst_i = 1'b1;
    @(negedge clk_i);
    `CHK({quarter_global_enable_o, watchdog_enable_o, multiplex_enable_o}, 3'h0)
    `CHK({outputs_enable_o, own_valid_o}, 2'h0)
    repeat (3) @(negedge clk_i);
    run(2'h3, 24'h1f1b1f, 24, 1'b1);
    `CHK(command_o, 2'h3)
    `CHK({quarter_global_enable_o, outputs_enable_o, watchdog_enable_o, multiplex_enable_o}, 4'h7)
    `CHK(n_counter_reset, 1)
    pop(8'h1f);
    pop(8'h1b);
    pop(8'h1f);
    run(2'h3, 24'h080800, 24, 1'b1);
    `CHK({quarter_global_enable_o, outputs_enable_o, watchdog_enable_o, multiplex_enable_o}, 4'h4)
    `CHK(n_counter_reset, 1)
    pop(8'h08);
    pop(8'h08);
    pop(8'h00);
    fault_overtemp_i = 1'b1;
    run(2'h1, 24'ha53c96, 24, 1'b1);
    `CHK(head_cap, 24'he85400)
    `CHK(command_o, 2'h1)
    pop(8'ha5);
    pop(8'h3c);
    pop(8'h96);
    run(2'h2, 24'h000000, 24, 1'b1);
    `CHK(head_cap, 24'he8a801)
    `CHK(command_o, 2'h2)
    for (int i = 0; i < 3; i++) pop(8'h00);
    k = n_head;
    run(2'h1, 24'h000000, 24, 1'b0);
    `CHK(n_ferr, 1)
    `CHK(n_head, k)
    fault_overtemp_i = 1'b0;
    fault_open_led_i = 1'b1;
    run(2'h0, 24'hc35a0f, 288, 1'b1);
    `CHK(head_cap, 24'he80000)
    `CHK(command_o, 2'h0)
    `CHK(own_overflow_o, 1'b1)
    for (int i = 0; i < 16; i++) pop(8'(24'hc35a0f >> (16 - 8 * (i % 3))));
    `CHK(own_valid_o, 1'b0)
    `CHK(n_head, 5)
    `CHK(n_cmd, 5)
    give_verdict();
  end
endmodule : tb_top
bind clsf_frontend clsf_frontend_props #(.PWM_WIDTH(PWM_WIDTH)) i_props (.clk_i, .nrst_i,
  .upstream_clock_in_i, .upstream_data_in_i, .upstream_frame_in_i, .fault_overtemp_i,
  .fault_open_led_i, .downstream_clock_out_o, .downstream_data_out_o, .downstream_frame_out_o,
  .command_o, .command_valid_o, .frame_error_o, .quarter_global_enable_o, .outputs_enable_o,
  .counter_reset_o, .watchdog_enable_o, .multiplex_enable_o, .own_data_o, .own_valid_o,
  .own_ready_i, .own_overflow_o);
`default_nettype wire
